// [core/chgim_pkg.sv]
// Package: offsets, field layout, reset values and carrier types of the charger event masks
package chgim_pkg;

    // Register offsets
    localparam logic [7:0] OFS_STATUS_IRQ_MASK_A = 8'h29;
    localparam logic [7:0] OFS_TIMER_IRQ_MASK = 8'h2a;
    localparam logic [7:0] OFS_THERMAL_ZONE_IRQ_MASK = 8'h2b;

    // Reset values
    localparam logic [7:0] RST_STATUS_IRQ_MASK_A = 8'h00;
    localparam logic [7:0] RST_TIMER_IRQ_MASK = 8'h00;
    localparam logic [7:0] RST_THERMAL_ZONE_IRQ_MASK = 8'h00;

    // Writable bits; the rest are reserved and read as zero
    localparam logic [7:0] WR_STATUS_IRQ_MASK_A = 8'hd7;
    localparam logic [7:0] WR_TIMER_IRQ_MASK = 8'h7f;
    localparam logic [7:0] WR_THERMAL_ZONE_IRQ_MASK = 8'h1f;

    // First register fields
    localparam int BIT_CHARGE_STATE = 7;
    localparam int BIT_CURRENT_OPTIMIZER = 6;
    localparam int BIT_INPUT_BUS = 4;
    localparam int BIT_THERMAL_REGULATION = 2;
    localparam int BIT_BATTERY_PRESENT = 1;
    localparam int BIT_CHARGER_DETECT = 0;

    // Second register fields
    localparam int BIT_DATA_LINE_DETECT = 6;
    localparam int BIT_ADC_DONE = 5;
    localparam int BIT_MIN_SYSTEM_REG = 4;
    localparam int BIT_FAST_CHARGE_TIMER = 3;
    localparam int BIT_TRICKLE_TIMER = 2;
    localparam int BIT_PRECHARGE_TIMER = 1;
    localparam int BIT_TOPOFF_TIMER = 0;

    // Third register fields
    localparam int BIT_BATTERY_LOW_FOR_SOURCE = 4;
    localparam int BIT_THERMISTOR_COLD = 3;
    localparam int BIT_THERMISTOR_COOL = 2;
    localparam int BIT_THERMISTOR_WARM = 1;
    localparam int BIT_THERMISTOR_HOT = 0;

    // Condition vector width; the bits that only count on entry (0 to 1)
    localparam int COND_W = 20;
    localparam logic [COND_W-1:0] COND_RISE_ONLY = 20'h04df0;

    // Interrupt pulse length in clock cycles
    localparam int INT_PULSE_CYCLES = 1;

    // Charger status condition levels
    typedef struct packed {
        logic [2:0] charge_state;
        logic current_optimizer;
        logic input_bus;
        logic thermal_regulation;
        logic battery_present;
        logic charger_detect;
        logic data_line_detect;
        logic adc_done;
        logic min_system_reg;
        logic fast_charge_timer;
        logic trickle_timer;
        logic precharge_timer;
        logic topoff_timer;
        logic battery_low_for_source;
        logic thermistor_cold;
        logic thermistor_cool;
        logic thermistor_warm;
        logic thermistor_hot;
    } chgim_cond_type;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } chgim_reg_req_type;

endpackage

// [core/chgim_mask_reg.sv]
// One byte-wide mask register with reserved bits and clear input
`timescale 1ns/1ps
`default_nettype none
module chgim_mask_reg
    import chgim_pkg::*;
#(
    parameter logic [7:0] WR_MASK = 8'hff,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Access
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire logic clr,
    // Value
    output logic [7:0] q
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // Clear beats a write in the same cycle
    assign q_nxt = clr ? RST_VAL : (wr_en ? (wdata & WR_MASK) : q_r);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// [core/chgim_change_detect.sv]
// Per-bit change detector for status levels
`timescale 1ns/1ps
`default_nettype none
module chgim_change_detect
    import chgim_pkg::*;
#(
    parameter int W = COND_W,
    parameter logic [W-1:0] RISE_ONLY = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels in, change pulses out
    input wire logic [W-1:0] level,
    output logic [W-1:0] change
);
    logic [W-1:0] prev_r;
    logic primed_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_r <= '0;
            primed_r <= 1'b0;
        end else begin
            prev_r <= level;
            primed_r <= 1'b1;
        end
    end

    // First cycle after reset only loads, so levels already high raise nothing
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (RISE_ONLY[i]) begin : g_rise
                assign change[i] = primed_r & level[i] & ~prev_r[i];
            end else begin : g_any
                assign change[i] = primed_r & (level[i] ^ prev_r[i]);
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [core/chgim_top.sv]
// Charger event interrupt masks: three mask registers gating status changes onto the interrupt
// Functional notes
// (R01) Charge-state mask bit 7 of first register: 1 blocks, 0 allows pulse on change.
// (R02) First register bit 6 masks input-current-optimizer status change interrupts.
// (R03) First register bit 4 masks input bus status change interrupts.
// (R04) First register bit 2 masks interrupt on entering thermal regulation.
// (R05) First register bit 1 masks battery-present status change interrupts.
// (R06) First register bit 0 masks charger-detection status change interrupts.
// (R07) Second register bit 6 masks data-line detection done pulse.
// (R08) Second register bit 5 masks converter done pulse, one-shot mode only.
// (R09) Second register bit 4 masks minimum-system regulation entry and exit pulses.
// (R10) Second register bit 3 masks fast-charge timer expiry interrupt.
// (R11) Second register bit 2 masks trickle timer expiry interrupt.
// (R12) Second register bit 1 masks pre-charge timer expiry interrupt.
// (R13) Second register bit 0 masks top-off timer expiry interrupt.
// (R14) Third register bit 4 masks battery too low for source output interrupt.
// (R15) Third register bit 3 masks thermistor cold threshold crossing.
// (R16) Third register bit 2 masks thermistor cool threshold crossing.
// (R17) Third register bit 1 masks thermistor warm threshold crossing.
// (R18) Third register bit 0 masks thermistor hot threshold crossing.
// (R19) All mask bits read/write and power up as zero.
// (R20) Register-reset clears all masks; watchdog expiry also clears third register.
// (R21) Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module chgim_top
    import chgim_pkg::*;
#(
    parameter int PULSE_CYCLES = INT_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire chgim_reg_req_type reg_req,
    output logic [7:0] rdata_r,
    output logic rvalid_r,
    // Device commands
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    // Charger status levels
    input wire chgim_cond_type cond,
    input wire logic adc_one_shot,
    // Interrupt to host
    output logic irq_b_r
);
    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES);

    // Address decode
    wire sel_a = (reg_req.addr == OFS_STATUS_IRQ_MASK_A);
    wire sel_b = (reg_req.addr == OFS_TIMER_IRQ_MASK);
    wire sel_c = (reg_req.addr == OFS_THERMAL_ZONE_IRQ_MASK);
    wire wr_a = reg_req.wr & sel_a;
    wire wr_b = reg_req.wr & sel_b;
    wire wr_c = reg_req.wr & sel_c;
    wire clr_ab = reg_reset; // R20
    wire clr_c = reg_reset | watchdog_expired; // R20

    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] mask_c;

    // Power-up zero, reserved bits held at zero by the write mask
    chgim_mask_reg #(
        .WR_MASK(WR_STATUS_IRQ_MASK_A), // R21
        .RST_VAL(RST_STATUS_IRQ_MASK_A) // R19
    ) u_mask_a (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_a),
        .wdata(reg_req.wdata),
        .clr(clr_ab),
        .q(mask_a)
    );

    chgim_mask_reg #(
        .WR_MASK(WR_TIMER_IRQ_MASK), // R21
        .RST_VAL(RST_TIMER_IRQ_MASK) // R19
    ) u_mask_b (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_b),
        .wdata(reg_req.wdata),
        .clr(clr_ab),
        .q(mask_b)
    );

    chgim_mask_reg #(
        .WR_MASK(WR_THERMAL_ZONE_IRQ_MASK), // R21
        .RST_VAL(RST_THERMAL_ZONE_IRQ_MASK) // R19
    ) u_mask_c (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_c),
        .wdata(reg_req.wdata),
        .clr(clr_c),
        .q(mask_c)
    );

    // Read mux; unmapped offsets read zero
    wire [7:0] rd_mux = sel_a ? mask_a : (sel_b ? mask_b : (sel_c ? mask_c : 8'h00)); // R19

    // Status change detection
    chgim_cond_type chg;

    chgim_change_detect #(
        .W(COND_W),
        .RISE_ONLY(COND_RISE_ONLY)
    ) u_detect (
        .clk(clk),
        .rst_b(rst_b),
        .level(cond),
        .change(chg)
    );

    // Gating: a set mask bit blocks its event
    wire hit_charge_state = (|chg.charge_state) & ~mask_a[BIT_CHARGE_STATE]; // R01
    wire hit_optimizer = chg.current_optimizer & ~mask_a[BIT_CURRENT_OPTIMIZER]; // R02
    wire hit_input_bus = chg.input_bus & ~mask_a[BIT_INPUT_BUS]; // R03
    wire hit_thermal_reg = chg.thermal_regulation & ~mask_a[BIT_THERMAL_REGULATION]; // R04
    wire hit_battery_present = chg.battery_present & ~mask_a[BIT_BATTERY_PRESENT]; // R05
    wire hit_charger_detect = chg.charger_detect & ~mask_a[BIT_CHARGER_DETECT]; // R06
    wire hit_data_line = chg.data_line_detect & ~mask_b[BIT_DATA_LINE_DETECT]; // R07
    // Continuous-mode conversions never interrupt
    wire hit_adc_done = chg.adc_done & adc_one_shot & ~mask_b[BIT_ADC_DONE]; // R08
    wire hit_min_system = chg.min_system_reg & ~mask_b[BIT_MIN_SYSTEM_REG]; // R09
    wire hit_fast_timer = chg.fast_charge_timer & ~mask_b[BIT_FAST_CHARGE_TIMER]; // R10
    wire hit_trickle_timer = chg.trickle_timer & ~mask_b[BIT_TRICKLE_TIMER]; // R11
    wire hit_precharge_timer = chg.precharge_timer & ~mask_b[BIT_PRECHARGE_TIMER]; // R12
    wire hit_topoff_timer = chg.topoff_timer & ~mask_b[BIT_TOPOFF_TIMER]; // R13
    wire hit_battery_low = chg.battery_low_for_source & ~mask_c[BIT_BATTERY_LOW_FOR_SOURCE]; // R14
    wire hit_cold = chg.thermistor_cold & ~mask_c[BIT_THERMISTOR_COLD]; // R15
    wire hit_cool = chg.thermistor_cool & ~mask_c[BIT_THERMISTOR_COOL]; // R16
    wire hit_warm = chg.thermistor_warm & ~mask_c[BIT_THERMISTOR_WARM]; // R17
    wire hit_hot = chg.thermistor_hot & ~mask_c[BIT_THERMISTOR_HOT]; // R18

    wire any_hit = hit_charge_state | hit_optimizer | hit_input_bus | hit_thermal_reg |
                   hit_battery_present | hit_charger_detect | hit_data_line | hit_adc_done |
                   hit_min_system | hit_fast_timer | hit_trickle_timer | hit_precharge_timer |
                   hit_topoff_timer | hit_battery_low | hit_cold | hit_cool | hit_warm | hit_hot;

    // Pulse stretcher; a new event restarts the pulse rather than queueing a second one
    logic [CNT_W-1:0] pulse_cnt_r;
    logic [CNT_W-1:0] pulse_cnt_nxt;

    assign pulse_cnt_nxt = any_hit ? PULSE_LOAD :
                           ((pulse_cnt_r != '0) ? pulse_cnt_r - CNT_W'(1) : pulse_cnt_r);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_cnt_r <= '0;
            irq_b_r <= 1'b1;
        end else begin
            pulse_cnt_r <= pulse_cnt_nxt;
            irq_b_r <= (pulse_cnt_nxt == '0);
        end
    end

    // Read data registered, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_req.rd;
            if (reg_req.rd) begin
                rdata_r <= rd_mux;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/chgim_props.sv]
// Checker of the charger event mask block
`timescale 1ns/1ps
`default_nettype none
module chgim_props
    import chgim_pkg::*;
#(
    parameter int PULSE_CYCLES = INT_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port and commands
    input wire chgim_reg_req_type reg_req,
    input wire logic [7:0] rdata_r,
    input wire logic rvalid_r,
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    // Status and interrupt
    input wire chgim_cond_type cond,
    input wire logic adc_one_shot,
    input wire logic irq_b_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rd_ans; reg_req.rd |=> rvalid_r; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_no_rv; !reg_req.rd |=> !rvalid_r; endproperty
    a_no_rv: assert property (p_no_rv) else $error("read answer without read");
    property p_rsv_a; reg_req.rd && reg_req.addr == OFS_STATUS_IRQ_MASK_A |=> (rdata_r & 8'h28) == 8'h00; endproperty
    a_rsv_a: assert property (p_rsv_a) else $error("first register spare bits set");
    property p_rsv_b; reg_req.rd && reg_req.addr == OFS_TIMER_IRQ_MASK |=> (rdata_r & 8'h80) == 8'h00; endproperty
    a_rsv_b: assert property (p_rsv_b) else $error("second register spare bit set");
    property p_rsv_c; reg_req.rd && reg_req.addr == OFS_THERMAL_ZONE_IRQ_MASK |=> rdata_r[7:5] == 3'h0; endproperty
    a_rsv_c: assert property (p_rsv_c) else $error("third register spare bits set");
    property p_unmap; reg_req.rd && !(reg_req.addr inside {[8'h29:8'h2b]}) |=> rdata_r == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_clr;
        reg_reset ##1 (reg_req.rd && reg_req.addr inside {[8'h29:8'h2b]}) |=> rdata_r == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("mask kept after register reset");
    property p_wd;
        watchdog_expired ##1 (reg_req.rd && reg_req.addr == OFS_THERMAL_ZONE_IRQ_MASK) |=> rdata_r == 8'h00;
    endproperty
    a_wd: assert property (p_wd) else $error("zone mask kept after watchdog");
    // Pulse may be longer than one cycle, so only a high line is held
    property p_quiet; $stable(cond) && irq_b_r |=> irq_b_r; endproperty
    a_quiet: assert property (p_quiet) else $error("interrupt without status change");
    // With the default length a pulse ends unless a new change arrives
    property p_one_pulse; (PULSE_CYCLES == 1) && !irq_b_r && $stable(cond) |=> irq_b_r; endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("interrupt pulse too long");
endmodule
bind chgim_top chgim_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (.clk(clk), .rst_b(rst_b),
    .reg_req(reg_req), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .reg_reset(reg_reset),
    .watchdog_expired(watchdog_expired), .cond(cond), .adc_one_shot(adc_one_shot), .irq_b_r(irq_b_r));
`default_nettype wire

// [testbench/chgim_host_model.sv]
// Host model counting interrupt pulses
`timescale 1ns/1ps
`default_nettype none
module chgim_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Interrupt line and pulse count
    input wire logic irq_b_r,
    output var int irq_cnt
);
    logic irq_prev_r;
    // Falling edges only, so a long pulse counts once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_prev_r <= 1'b1;
            irq_cnt <= 0;
        end else begin
            irq_prev_r <= irq_b_r;
            if (irq_prev_r && !irq_b_r) begin
                irq_cnt <= irq_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/tb_charger_event_interrupt_masks.sv]
// Testbench of the charger event mask block
`timescale 1ns/1ps
`default_nettype none
module tb_charger_event_interrupt_masks
    import chgim_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    chgim_reg_req_type req = '0;
    chgim_cond_type cond = '0;
    logic reg_reset = 1'b0;
    logic wd_exp = 1'b0;
    logic one_shot = 1'b1;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic irq_b_r;
    int irq_cnt;
    int num_errors = 0;
    int tests_run = 0;
    int n_adc = 0;
    int bmap[5] = '{0, 1, 2, 4, 6};
    logic [7:0] ofs[4] = '{8'h29, 8'h2a, 8'h2b, 8'h2c};
    logic [7:0] wrv[4] = '{8'hd7, 8'h7f, 8'h1f, 8'h00};
    always #10 clk = ~clk;
    chgim_top i_dut (.clk(clk), .rst_b(rst_b), .reg_req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
        .reg_reset(reg_reset), .watchdog_expired(wd_exp), .cond(cond), .adc_one_shot(one_shot), .irq_b_r(irq_b_r));
    chgim_host_model i_host (.clk(clk), .rst_b(rst_b), .irq_b_r(irq_b_r), .irq_cnt(irq_cnt));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(1);
        req = '0;
        // Idle cycle keeps the strobe from being reassigned in one time step
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        cyc(1);
        req = '0;
        chk("rvalid", {31'h0, rvalid_r}, 32'h1);
        chk("rdata", {24'h0, rdata_r}, {24'h0, exp});
        cyc(1);
    endtask
    // One status bit raised then lowered, with its mask bit set to m
    task automatic ev(input int ci, input logic m);
        logic [7:0] a;
        int b;
        int n0;
        a = ci > 11 ? OFS_STATUS_IRQ_MASK_A : (ci > 4 ? OFS_TIMER_IRQ_MASK : OFS_THERMAL_ZONE_IRQ_MASK);
        b = ci > 16 ? 7 : (ci > 11 ? bmap[ci-12] : (ci > 4 ? ci - 5 : ci));
        wr(a, 8'(m) << b);
        n0 = irq_cnt;
        cond[ci] = 1'b1;
        cyc(3);
        chk("rise irq", irq_cnt - n0, 32'(!m));
        cond[ci] = 1'b0;
        cyc(3);
        chk("fall irq", irq_cnt - n0, 32'(!m) + 32'(!(m | COND_RISE_ONLY[ci])));
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        rst_b = 1'b1;
        cyc(2);
        for (int i = 0; i < 4; i++) rd(ofs[i], 8'h00);
        for (int i = 0; i < 4; i++) wr(ofs[i], 8'hff);
        for (int i = 0; i < 4; i++) rd(ofs[i], wrv[i]);
        reg_reset = 1'b1;
        cyc(1);
        reg_reset = 1'b0;
        for (int i = 0; i < 3; i++) rd(ofs[i], 8'h00);
        wr(OFS_TIMER_IRQ_MASK, 8'h7f);
        wr(OFS_THERMAL_ZONE_IRQ_MASK, 8'h1f);
        wd_exp = 1'b1;
        cyc(1);
        wd_exp = 1'b0;
        rd(OFS_THERMAL_ZONE_IRQ_MASK, 8'h00);
        rd(OFS_TIMER_IRQ_MASK, 8'h7f);
        for (int ci = 12; ci < 20; ci++) for (int m = 0; m < 2; m++) ev(ci, m[0]);
        for (int ci = 5; ci < 12; ci++) for (int m = 0; m < 2; m++) ev(ci, m[0]);
        for (int ci = 0; ci < 5; ci++) for (int m = 0; m < 2; m++) ev(ci, m[0]);
        // Converter done outside one-shot mode stays silent
        wr(OFS_TIMER_IRQ_MASK, 8'h00);
        one_shot = 1'b0;
        n_adc = irq_cnt;
        cond[10] = 1'b1;
        cyc(3);
        chk("adc irq", irq_cnt - n_adc, 32'h0);
        // Mid-run reset: masks back to zero, a level standing at release raises nothing
        wr(OFS_STATUS_IRQ_MASK_A, 8'hd7);
        one_shot = 1'b1;
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        rd(OFS_STATUS_IRQ_MASK_A, 8'h00);
        cyc(2);
        chk("reset irq", irq_cnt, 32'h0);
        stop_test();
    end
    initial begin
        cyc(5000);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
